/* File: hdl/hbp_pkg.sv */
// Constants shared by the host bus parallel port design
package hbp_pkg;

    localparam int DATA_W = 8;

    // Control/status register bit positions
    localparam int CSR_GATE_HI = 7;
    localparam int CSR_GATE_LO = 6;
    localparam int CSR_SEL_HI  = 5;
    localparam int CSR_SEL_LO  = 4;
    localparam int CSR_OFC     = 3;
    localparam int CSR_ISEM    = 2;
    localparam int CSR_OFF     = 1;
    localparam int CSR_IFF     = 0;

    // Mode bits 7..2 come up all ones: bus interface mode
    localparam logic [7:2] CSR_MODE_RESET = 6'h3f;

    // Idle levels of select, gate, input strobe, output strobe
    localparam logic [3:0] PIN_CTRL_IDLE = 4'h3;
    localparam int PIN_SEL  = 3;
    localparam int PIN_GATE = 2;
    localparam int PIN_ISTB = 1;
    localparam int PIN_OSTB = 0;

    // Function of the select pin and of the gate pin
    typedef enum logic [1:0]
    {
        PM_LEVEL0 = 2'b00,
        PM_LEVEL1 = 2'b01,
        PM_FLAG   = 2'b10,
        PM_INPUT  = 2'b11
    } hbp_pin_mode_type;

endpackage

/* File: hdl/hbp_sync_if.sv */
// Synchronised pin levels and strobe edges between the two port modules
`timescale 1ns/100ps
interface hbp_sync_if;
    logic                           sel_lvl;
    logic                           gate_lvl;
    logic                           istb_lvl;
    logic                           ostb_lvl;
    logic                           istb_rise;
    logic                           istb_fall;
    logic                           ostb_rise;
    logic                           ostb_fall;
    logic [hbp_pkg::DATA_W-1:0]     data_lvl;

    modport drv (output sel_lvl, gate_lvl, istb_lvl, ostb_lvl,
                 output istb_rise, istb_fall, ostb_rise, ostb_fall, data_lvl);
    modport use_side (input sel_lvl, gate_lvl, istb_lvl, ostb_lvl,
                      input istb_rise, istb_fall, ostb_rise, ostb_fall, data_lvl);
endinterface

/* File: hdl/hbp_pin_sync.sv */
// Two-stage synchroniser and strobe edge detector for the port pins
`timescale 1ns/100ps
module hbp_pin_sync #(
    parameter int DW = hbp_pkg::DATA_W
)(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          select_pin_i,
    input  wire logic          gate_pin_i,
    input  wire logic          input_strobe_n_i,
    input  wire logic          output_strobe_n_i,
    input  wire logic [DW-1:0] port_data_i,
    hbp_sync_if.drv            sb
);

    logic [3:0]    ctrl_meta_q;
    logic [3:0]    ctrl_sync_q;
    logic [3:0]    ctrl_prev_q;
    logic [DW-1:0] data_meta_q;
    logic [DW-1:0] data_sync_q;

    // Data goes through the same two stages so it lines up with the strobes
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_meta_q <= hbp_pkg::PIN_CTRL_IDLE;
            ctrl_sync_q <= hbp_pkg::PIN_CTRL_IDLE;
            ctrl_prev_q <= hbp_pkg::PIN_CTRL_IDLE;
            data_meta_q <= '0;
            data_sync_q <= '0;
        end
        else
        begin
            ctrl_meta_q <= {select_pin_i, gate_pin_i, input_strobe_n_i, output_strobe_n_i};
            ctrl_sync_q <= ctrl_meta_q;
            ctrl_prev_q <= ctrl_sync_q;
            data_meta_q <= port_data_i;
            data_sync_q <= data_meta_q;
        end
    end

    assign sb.sel_lvl   = ctrl_sync_q[hbp_pkg::PIN_SEL];
    assign sb.gate_lvl  = ctrl_sync_q[hbp_pkg::PIN_GATE];
    assign sb.istb_lvl  = ctrl_sync_q[hbp_pkg::PIN_ISTB];
    assign sb.ostb_lvl  = ctrl_sync_q[hbp_pkg::PIN_OSTB];
    // Edges come from the second stage only, one pulse per pin edge
    assign sb.istb_rise = ctrl_sync_q[hbp_pkg::PIN_ISTB] & ~ctrl_prev_q[hbp_pkg::PIN_ISTB];
    assign sb.istb_fall = ~ctrl_sync_q[hbp_pkg::PIN_ISTB] & ctrl_prev_q[hbp_pkg::PIN_ISTB];
    assign sb.ostb_rise = ctrl_sync_q[hbp_pkg::PIN_OSTB] & ~ctrl_prev_q[hbp_pkg::PIN_OSTB];
    assign sb.ostb_fall = ~ctrl_sync_q[hbp_pkg::PIN_OSTB] & ctrl_prev_q[hbp_pkg::PIN_OSTB];
    assign sb.data_lvl  = data_sync_q;

    property p_single_edge;
        @(posedge sys_clk_i) disable iff (rst_i)
        sb.istb_rise |=> !sb.istb_rise ##1 !sb.istb_rise;
    endproperty
    a_single_edge: assert property (p_single_edge)
        else $error("input strobe edge pulse longer than one cycle");

endmodule

/* File: hdl/hbp_port.sv */
// Host bus parallel port: data latches, buffer flags and control/status register
// Summary of operation
// - Reset sets status register bits two to seven
// - Select high reads status, low reads latch
// - Gate high blocks latches and flags, and drivers outside output-only mode
// - Gate low allows strobed host reads, writes
// - Input full flag is status bit zero
// - Host write loads latch, sets input flag
// - Internal read returns latch, clears input flag
// - Output flag tracks unread internal writes
// - Discard read after reset clears stray flag
// - Firmware may drive select, gate as outputs
// - Strobed input latches and flags on rise while status bit two is clear
// - Output flag clears on output strobe rise, or fall if status bit three is set
// - Output-only mode keeps drivers always enabled
`timescale 1ns/100ps
module hbp_port #(
    parameter int DW = hbp_pkg::DATA_W
)(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          select_pin_i,
    output wire logic          select_pin_o,
    output wire logic          select_pin_oe_o,
    input  wire logic          gate_pin_i,
    output wire logic          gate_pin_o,
    output wire logic          gate_pin_oe_o,
    input  wire logic          input_strobe_n_i,
    input  wire logic          output_strobe_n_i,
    input  wire logic [DW-1:0] port_data_i,
    output wire logic [DW-1:0] port_data_o,
    output wire logic          port_data_oe_o,
    input  wire logic          cpu_out_wr_i,
    input  wire logic [DW-1:0] cpu_out_data_i,
    input  wire logic          cpu_in_rd_i,
    output wire logic [DW-1:0] cpu_in_data_o,
    input  wire logic          cpu_csr_wr_i,
    input  wire logic [7:0]    cpu_csr_data_i,
    output wire logic [7:0]    cpu_csr_o
);

    hbp_sync_if sync_bus ();

    hbp_pin_sync #(
        .DW (DW)
    ) u_sync (
        .sys_clk_i         (sys_clk_i),
        .rst_i             (rst_i),
        .select_pin_i      (select_pin_i),
        .gate_pin_i        (gate_pin_i),
        .input_strobe_n_i  (input_strobe_n_i),
        .output_strobe_n_i (output_strobe_n_i),
        .port_data_i       (port_data_i),
        .sb                (sync_bus.drv)
    );

    // Registers
    logic [7:2]    mode_q;
    logic [7:2]    mode_d;
    logic          in_full_q;
    logic          in_full_d;
    logic          out_full_q;
    logic          out_full_d;
    logic [DW-1:0] in_latch_q;
    logic [DW-1:0] in_latch_d;
    logic [DW-1:0] out_latch_q;
    logic [DW-1:0] out_latch_d;
    logic [DW-1:0] pd_q;
    logic [DW-1:0] pd_d;
    logic          pd_oe_q;
    logic          pd_oe_d;
    logic          sel_o_q;
    logic          sel_o_d;
    logic          gate_o_q;
    logic          gate_o_d;

    // Mode decode
    hbp_pkg::hbp_pin_mode_type sel_mode;
    hbp_pkg::hbp_pin_mode_type gate_mode;
    wire logic          sel_is_input;
    wire logic          gate_is_input;
    wire logic          out_only;
    wire logic          edge_mode;
    wire logic          clear_on_fall;
    wire logic          port_en;
    wire logic          host_rd;
    wire logic          host_sel_csr;
    wire logic          in_full_set;
    wire logic          out_full_clr;
    wire logic          latch_load;
    wire logic [7:0]    csr_vec;

    assign sel_mode      = hbp_pkg::hbp_pin_mode_type'(
                               mode_q[hbp_pkg::CSR_SEL_HI:hbp_pkg::CSR_SEL_LO]);
    assign gate_mode     = hbp_pkg::hbp_pin_mode_type'(
                               mode_q[hbp_pkg::CSR_GATE_HI:hbp_pkg::CSR_GATE_LO]);
    assign sel_is_input  = (sel_mode == hbp_pkg::PM_INPUT);
    assign gate_is_input = (gate_mode == hbp_pkg::PM_INPUT);
    assign out_only      = (sel_mode == hbp_pkg::PM_FLAG);
    assign edge_mode     = mode_q[hbp_pkg::CSR_ISEM];
    assign clear_on_fall = mode_q[hbp_pkg::CSR_OFC];

    // Gate high shuts the port off; with gate as an output the port is always on
    assign port_en       = gate_is_input ? ~sync_bus.gate_lvl : 1'b1;
    assign host_rd       = port_en & ~sync_bus.ostb_lvl;
    assign host_sel_csr  = sel_is_input & sync_bus.sel_lvl;

    // Input side: level mode keeps the latch open while the strobe is low
    assign in_full_set   = port_en & (edge_mode ? sync_bus.istb_fall : sync_bus.istb_rise);
    assign latch_load    = port_en & (edge_mode ? ~sync_bus.istb_lvl : sync_bus.istb_rise);
    // Status polls leave the output flag alone, else the host could never see it
    assign out_full_clr  = port_en & ~host_sel_csr
                         & (clear_on_fall ? sync_bus.ostb_fall : sync_bus.ostb_rise);

    assign csr_vec       = {mode_q, out_full_q, in_full_q};

    // Flags: a set in the same cycle as a clear wins
    assign in_full_d     = in_full_set | (in_full_q & ~cpu_in_rd_i);
    assign out_full_d    = cpu_out_wr_i | (out_full_q & ~out_full_clr);
    assign in_latch_d    = latch_load ? sync_bus.data_lvl : in_latch_q;
    assign out_latch_d   = cpu_out_wr_i ? cpu_out_data_i : out_latch_q;
    assign mode_d        = cpu_csr_wr_i ? cpu_csr_data_i[7:2] : mode_q;

    // Drivers: status only reachable through select in bus mode
    assign pd_d          = (host_sel_csr & ~out_only) ? csr_vec : out_latch_q;
    assign pd_oe_d       = out_only | host_rd;
    assign sel_o_d       = out_only ? out_full_q : mode_q[hbp_pkg::CSR_SEL_LO];
    assign gate_o_d      = (gate_mode == hbp_pkg::PM_FLAG) ? in_full_q
                                                          : mode_q[hbp_pkg::CSR_GATE_LO];

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            mode_q     <= hbp_pkg::CSR_MODE_RESET;
            in_full_q  <= 1'b0;
            out_full_q <= 1'b0;
            in_latch_q <= '0;
            out_latch_q <= '0;
        end
        else
        begin
            mode_q     <= mode_d;
            in_full_q  <= in_full_d;
            out_full_q <= out_full_d;
            in_latch_q <= in_latch_d;
            out_latch_q <= out_latch_d;
        end
    end

    // Pin drivers off through reset so the host bus is left alone
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pd_q     <= '0;
            pd_oe_q  <= 1'b0;
            sel_o_q  <= 1'b0;
            gate_o_q <= 1'b0;
        end
        else
        begin
            pd_q     <= pd_d;
            pd_oe_q  <= pd_oe_d;
            sel_o_q  <= sel_o_d;
            gate_o_q <= gate_o_d;
        end
    end

    assign port_data_o     = pd_q;
    assign port_data_oe_o  = pd_oe_q;
    assign select_pin_o    = sel_o_q;
    assign select_pin_oe_o = ~sel_is_input;
    assign gate_pin_o      = gate_o_q;
    assign gate_pin_oe_o   = ~gate_is_input;
    assign cpu_in_data_o   = in_latch_q;
    assign cpu_csr_o       = csr_vec;

    property p_reset_mode;
        @(posedge sys_clk_i)
        rst_i |=> (cpu_csr_o[7:2] == hbp_pkg::CSR_MODE_RESET) && !select_pin_oe_o && !gate_pin_oe_o;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("mode bits not all ones after reset");

    property p_rise_sets_full;
        @(posedge sys_clk_i) disable iff (rst_i)
        port_en && !edge_mode && sync_bus.istb_rise
            |=> in_full_q && (cpu_in_data_o == $past(sync_bus.data_lvl));
    endproperty
    a_rise_sets_full: assert property (p_rise_sets_full)
        else $error("input strobe rise did not latch data and set flag");

    property p_read_clears;
        @(posedge sys_clk_i) disable iff (rst_i)
        cpu_in_rd_i && !in_full_set |=> !cpu_csr_o[0];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("internal read did not clear input full flag");

    property p_gate_blocks;
        @(posedge sys_clk_i) disable iff (rst_i)
        gate_is_input && sync_bus.gate_lvl && !cpu_in_rd_i && !cpu_csr_wr_i
            |=> $stable(in_full_q) && $stable(in_latch_q) && !port_data_oe_o;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks)
        else $error("port acted while gate high");

    property p_select_status;
        @(posedge sys_clk_i) disable iff (rst_i)
        host_rd && host_sel_csr && !out_only
            |=> port_data_oe_o && (port_data_o == $past(csr_vec));
    endproperty
    a_select_status: assert property (p_select_status)
        else $error("select high did not return status register");

    property p_out_only_drive;
        @(posedge sys_clk_i) disable iff (rst_i)
        out_only && !cpu_csr_wr_i |=> port_data_oe_o ##1 (port_data_oe_o || $past(cpu_csr_wr_i));
    endproperty
    a_out_only_drive: assert property (p_out_only_drive)
        else $error("drivers off in output-only mode");

    property p_out_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        out_full_clr && !cpu_out_wr_i |=> !out_full_q;
    endproperty
    a_out_clear: assert property (p_out_clear)
        else $error("output strobe did not clear output full flag");

    property p_out_set;
        @(posedge sys_clk_i) disable iff (rst_i)
        cpu_out_wr_i |=> cpu_csr_o[1] && (out_latch_q == $past(cpu_out_data_i));
    endproperty
    a_out_set: assert property (p_out_set)
        else $error("internal write did not set output full flag");

    property p_level_latch;
        @(posedge sys_clk_i) disable iff (rst_i)
        port_en && edge_mode && !sync_bus.istb_lvl |=> in_latch_q == $past(sync_bus.data_lvl);
    endproperty
    a_level_latch: assert property (p_level_latch)
        else $error("host write data not latched while strobe low");

    property p_fall_sets_full;
        @(posedge sys_clk_i) disable iff (rst_i)
        port_en && edge_mode && sync_bus.istb_fall |=> in_full_q;
    endproperty
    a_fall_sets_full: assert property (p_fall_sets_full)
        else $error("input strobe fall did not set input full flag");

    property p_fall_ignored;
        @(posedge sys_clk_i) disable iff (rst_i)
        !edge_mode && sync_bus.istb_fall && !cpu_in_rd_i
            |=> $stable(in_full_q) && $stable(in_latch_q);
    endproperty
    a_fall_ignored: assert property (p_fall_ignored)
        else $error("input strobe fall acted in rising edge mode");

    property p_reset_flags;
        @(posedge sys_clk_i)
        rst_i |=> !in_full_q && !out_full_q && !port_data_oe_o;
    endproperty
    a_reset_flags: assert property (p_reset_flags)
        else $error("flags or drivers active after reset");

    property p_data_read;
        @(posedge sys_clk_i) disable iff (rst_i)
        host_rd && !host_sel_csr && !out_only
            |=> port_data_oe_o && (port_data_o == $past(out_latch_q));
    endproperty
    a_data_read: assert property (p_data_read)
        else $error("host read did not return output latch");

    property p_status_keeps_out;
        @(posedge sys_clk_i) disable iff (rst_i)
        port_en && host_sel_csr && (sync_bus.ostb_fall || sync_bus.ostb_rise) && !cpu_out_wr_i
            |=> $stable(out_full_q);
    endproperty
    a_status_keeps_out: assert property (p_status_keeps_out)
        else $error("status read changed output full flag");

    property p_fall_no_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        !clear_on_fall && sync_bus.ostb_fall && !cpu_out_wr_i |=> $stable(out_full_q);
    endproperty
    a_fall_no_clear: assert property (p_fall_no_clear)
        else $error("output flag cleared on wrong strobe edge");

    property p_csr_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        cpu_csr_wr_i
            |=> mode_q == $past(cpu_csr_data_i[hbp_pkg::CSR_GATE_HI:hbp_pkg::CSR_ISEM]);
    endproperty
    a_csr_write: assert property (p_csr_write)
        else $error("mode bits not loaded by status register write");

    property p_sel_flag_out;
        @(posedge sys_clk_i) disable iff (rst_i)
        out_only |=> select_pin_o == $past(out_full_q);
    endproperty
    a_sel_flag_out: assert property (p_sel_flag_out)
        else $error("select pin does not show output full flag");

    property p_gate_flag_out;
        @(posedge sys_clk_i) disable iff (rst_i)
        gate_mode == hbp_pkg::PM_FLAG |=> gate_pin_o == $past(in_full_q);
    endproperty
    a_gate_flag_out: assert property (p_gate_flag_out)
        else $error("gate pin does not show input full flag");

endmodule

/* File: tb/hbp_host_model.sv */
// Host processor bus model driving the port pins
`timescale 1ns/100ps
module hbp_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] bus_i,
    output logic            select_o,
    output logic            gate_n_o,
    output logic            istb_n_o,
    output logic            ostb_n_o,
    output logic [7:0]      data_o,
    output logic            drive_o
);
    initial
    begin
        select_o = 1'b0;
        gate_n_o = 1'b1;
        istb_n_o = 1'b1;
        ostb_n_o = 1'b1;
        data_o   = 8'h00;
        drive_o  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Six clocks per phase, so the pin synchroniser always sees the level
    task automatic set_in(input logic g_n, input logic stb_n, input logic [7:0] d);
        select_o = 1'b0;
        gate_n_o = g_n;
        data_o   = d;
        drive_o  = 1'b1;
        istb_n_o = stb_n;
        wait_clk(6);
    endtask

    task automatic set_out(input logic g_n, input logic a0, input logic stb_n,
                           output logic [7:0] d);
        select_o = a0;
        gate_n_o = g_n;
        drive_o  = 1'b0;
        ostb_n_o = stb_n;
        wait_clk(6);
        d = bus_i;
    endtask

    // Released bus floats to the pull-up level, not the last byte
    task automatic idle();
        gate_n_o = 1'b1;
        drive_o  = 1'b0;
        istb_n_o = 1'b1;
        ostb_n_o = 1'b1;
        wait_clk(2);
    endtask
endmodule

/* File: tb/host_bus_parallel_port_tb_top.sv */
// Self-checking bench for the host bus parallel port
`timescale 1ns/100ps
module host_bus_parallel_port_tb_top;
    logic       sys_clk_i;
    logic       rst_i;
    logic       cpu_out_wr;
    logic [7:0] cpu_out_data;
    logic       cpu_in_rd;
    logic       cpu_csr_wr;
    logic [7:0] cpu_csr_data;
    logic       sel_h, gate_h, istb_n, ostb_n, drv;
    logic [7:0] hdata;
    wire logic       sel_o, sel_oe, gate_o, gate_oe, pd_oe;
    wire logic [7:0] pd_o, cpu_in_data, cpu_csr;
    wire logic       sel_w  = sel_oe ? sel_o : sel_h;
    wire logic       gate_w = gate_oe ? gate_o : gate_h;
    wire logic [7:0] bus_w  = pd_oe ? pd_o : (drv ? hdata : 8'hff);
    int   mismatches = 0;
    int   num_checks = 0;
    int   cycles     = 0;
    logic [7:0] b;

    hbp_port i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .select_pin_i(sel_w), .select_pin_o(sel_o), .select_pin_oe_o(sel_oe),
        .gate_pin_i(gate_w), .gate_pin_o(gate_o), .gate_pin_oe_o(gate_oe),
        .input_strobe_n_i(istb_n), .output_strobe_n_i(ostb_n),
        .port_data_i(bus_w), .port_data_o(pd_o), .port_data_oe_o(pd_oe),
        .cpu_out_wr_i(cpu_out_wr), .cpu_out_data_i(cpu_out_data),
        .cpu_in_rd_i(cpu_in_rd), .cpu_in_data_o(cpu_in_data),
        .cpu_csr_wr_i(cpu_csr_wr), .cpu_csr_data_i(cpu_csr_data), .cpu_csr_o(cpu_csr));

    hbp_host_model i_host (.sys_clk_i(sys_clk_i), .bus_i(bus_w), .select_o(sel_h),
        .gate_n_o(gate_h), .istb_n_o(istb_n), .ostb_n_o(ostb_n), .data_o(hdata),
        .drive_o(drv));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // Ceiling well above the roughly 125 cycles the tests need
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // op bit 0 output write, bit 1 input read, bit 2 status write
    task automatic cpu_op(input logic [2:0] op, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        {cpu_csr_wr, cpu_in_rd, cpu_out_wr} = op;
        cpu_out_data = d;
        cpu_csr_data = d;
        @(posedge sys_clk_i);
        #1;
        {cpu_csr_wr, cpu_in_rd, cpu_out_wr} = 3'b000;
    endtask

    task automatic t_reset();
        check(cpu_csr, 8'hfc, "status after reset");
        check({6'h00, sel_oe, gate_oe}, 8'h00, "pins are inputs");
        check({7'h00, pd_oe}, 8'h00, "drivers off");
        cpu_op(3'b010, 8'h00);
        check(cpu_csr, 8'hfc, "discard read");
        $display("test reset done");
    endtask

    task automatic t_host_write();
        i_host.set_out(1'b0, 1'b1, 1'b0, b);
        check(b, 8'hfc, "host sees input flag clear");
        i_host.set_out(1'b0, 1'b1, 1'b1, b);
        i_host.set_in(1'b0, 1'b0, 8'ha5);
        i_host.set_in(1'b0, 1'b1, 8'ha5);
        i_host.idle();
        check(cpu_csr, 8'hfd, "input flag set");
        check(cpu_in_data, 8'ha5, "input latch");
        cpu_op(3'b010, 8'h00);
        check(cpu_csr, 8'hfc, "input flag cleared by read");
        $display("test host write done");
    endtask

    task automatic t_gate_off();
        i_host.set_in(1'b1, 1'b0, 8'h11);
        i_host.set_in(1'b1, 1'b1, 8'h11);
        i_host.set_out(1'b1, 1'b0, 1'b0, b);
        check({7'h00, pd_oe}, 8'h00, "drivers stay off");
        i_host.idle();
        check(cpu_csr, 8'hfc, "flags untouched");
        check(cpu_in_data, 8'ha5, "latch untouched");
        $display("test gate off done");
    endtask

    task automatic t_host_read();
        cpu_op(3'b001, 8'h96);
        check(cpu_csr, 8'hfe, "output flag set");
        i_host.set_out(1'b0, 1'b1, 1'b0, b);
        check(b, 8'hfe, "status read");
        i_host.set_out(1'b0, 1'b1, 1'b1, b);
        i_host.set_out(1'b0, 1'b0, 1'b0, b);
        check(b, 8'h96, "data read");
        i_host.set_out(1'b0, 1'b0, 1'b1, b);
        i_host.idle();
        check(cpu_csr, 8'hfc, "output flag cleared");
        $display("test host read done");
    endtask

    task automatic t_rise_latch();
        cpu_op(3'b100, 8'h9b);
        check(cpu_csr, 8'h98, "low status bits read only");
        check({6'h00, gate_oe, sel_o}, 8'h03, "pins as outputs");
        i_host.set_in(1'b1, 1'b0, 8'hc3);
        check(cpu_csr, 8'h98, "no flag on strobe fall");
        check(cpu_in_data, 8'ha5, "no latch on strobe fall");
        i_host.set_in(1'b1, 1'b1, 8'hc3);
        i_host.idle();
        check(cpu_csr, 8'h99, "flag on strobe rise");
        check(cpu_in_data, 8'hc3, "latched at rise");
        check({7'h00, gate_o}, 8'h01, "gate shows input flag");
        cpu_op(3'b010, 8'h00);
        $display("test rise latch done");
    endtask

    task automatic t_out_only();
        cpu_op(3'b100, 8'h64);
        i_host.wait_clk(1);
        check({7'h00, pd_oe}, 8'h01, "drivers always on");
        cpu_op(3'b001, 8'h3c);
        i_host.wait_clk(1);
        check(pd_o, 8'h3c, "output latch driven");
        check({7'h00, sel_o}, 8'h01, "select shows output flag");
        i_host.set_out(1'b1, 1'b0, 1'b0, b);
        check(b, 8'h3c, "host sees output latch");
        check(cpu_csr, 8'h66, "no clear on fall");
        check({7'h00, pd_oe}, 8'h01, "drivers on during strobe");
        i_host.set_out(1'b1, 1'b0, 1'b1, b);
        check(cpu_csr, 8'h64, "clear on rise");
        check({7'h00, sel_o}, 8'h00, "select follows flag");
        $display("test output only done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        rst_i        = 1'b1;
        cpu_out_wr   = 1'b0;
        cpu_out_data = 8'h00;
        cpu_in_rd    = 1'b0;
        cpu_csr_wr   = 1'b0;
        cpu_csr_data = 8'h00;
        repeat (10) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        t_host_write();
        t_gate_off();
        t_host_read();
        t_rise_latch();
        t_out_only();
        stop_test();
    end
endmodule
